/* hubc_uart.sv */
// Function
// RL1: Exponent zero: bit rate reference over mantissa+1.
// RL2: Otherwise reference/(mantissa+33)/2^(exponent-1).
// RL3: Frame is start, eight data, stop.
// RL4: No parity bit sent or expected.
// RL5: Host keeps rate at most 1228.8 kbit/s.
// RL6: Rate register resets to 7Ah, 115.2 kbit/s.
// RL7: Writing rate fields changes link bit rate.
// RL8: Host uses codes 3A, 1C, 15 for fast rates.
// RL9: Idle high, LSB first, mid-bit sampling.
`timescale 1ns/1ps

module hubc_uart
    import hubc_pkg::*;
(
    input  wire logic       i_mclk,   // 25 MHz clock
    input  wire logic       i_rst_b,  // Asynchronous reset, active low
    input  wire logic [7:0] i_addr,   // Register address
    input  wire logic [7:0] i_wdata,  // Register write data
    input  wire logic       i_wr,     // Write strobe
    input  wire logic       i_rd,     // Read strobe
    output logic      [7:0] o_rdata,  // Read data, cycle after strobe
    input  wire logic       i_rxd,    // Serial line from host
    output logic            o_txd     // Serial line to host
);

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic [1:0] rst_sync;
    logic       rst_n;

    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rst_sync <= 2'h0;
        end
        else
        begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  rate;
        logic [23:0] acc;
        logic        os_tick;
        hubc_ser_t   tx_state;
        logic [7:0]  tx_shift;
        logic [2:0]  tx_bit;
        logic [3:0]  tx_os;
        logic        txd;
        hubc_ser_t   rx_state;
        logic [7:0]  rx_shift;
        logic [2:0]  rx_bit;
        logic [3:0]  rx_os;
        logic [7:0]  rx_data;
        logic        rx_valid;
        logic        rx_overrun;
        logic        rx_frame_err;
        logic [7:0]  rdata;
    } hubc_state_t;

    hubc_state_t s;
    hubc_state_t next_s;

    logic [12:0] div_ticks;
    logic [23:0] threshold;
    logic [23:0] acc_sum;
    logic        fifo_push;
    logic        fifo_ready;
    logic        fifo_valid;
    logic        fifo_pop;
    logic [7:0]  fifo_data;
    logic        rd_data;
    logic        rd_status;
    logic        tx_bit_end;
    logic        rx_byte_done;

    // ----------------------------------------------------------------
    // Bit rate divisor in reference clock periods
    // ----------------------------------------------------------------
    always_comb
    begin
        if (s.rate[EXP_MSB:EXP_LSB] == 3'h0)
        begin
            div_ticks = 13'(s.rate[MAN_MSB:MAN_LSB]) + 13'h0001; // RL1
        end
        else
        begin
            div_ticks = (13'(s.rate[MAN_MSB:MAN_LSB]) + 13'(MAN_OFFSET_EXP))
                        << (s.rate[EXP_MSB:EXP_LSB] - 3'h1); // RL2
        end
    end

    // The reference runs faster than i_mclk, so a fractional accumulator
    // emulates it; the resulting edge jitter is one mclk period, which is
    // under a sixteenth of a bit at every rate up to the supported limit.
    assign threshold = 24'(div_ticks) * 24'(MCLK_WEIGHT);
    assign acc_sum   = s.acc + ACC_STEP;

    assign fifo_push    = i_wr && (i_addr == ADDR_DATA);
    assign rd_data      = i_rd && (i_addr == ADDR_DATA);
    assign rd_status    = i_rd && (i_addr == ADDR_STATUS);
    assign tx_bit_end   = s.os_tick && (s.tx_os == OS_LAST);
    assign rx_byte_done = s.os_tick && (s.rx_state == HUBC_STOP) && (s.rx_os == OS_LAST);
    assign fifo_pop     = (s.tx_state == HUBC_IDLE) && fifo_valid;

    // ----------------------------------------------------------------
    // Transmit buffer
    // ----------------------------------------------------------------
    hubc_fifo #(
        .WIDTH (8),
        .DEPTH (TX_FIFO_DEPTH)
    ) u_tx_fifo (
        .i_mclk      (i_mclk),
        .i_rst_n     (rst_n),
        .i_in_valid  (fifo_push),
        .o_in_ready  (fifo_ready),
        .i_in_data   (i_wdata),
        .o_out_valid (fifo_valid),
        .i_out_ready (fifo_pop),
        .o_out_data  (fifo_data)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        next_s = s;

        if (acc_sum >= threshold)
        begin
            next_s.acc     = acc_sum - threshold;
            next_s.os_tick = 1'b1;
        end
        else
        begin
            next_s.acc     = acc_sum;
            next_s.os_tick = 1'b0;
        end
        // A rate write restarts the accumulator; otherwise a smaller new
        // divisor would drain the old remainder as a burst of ticks.
        if (i_wr && (i_addr == ADDR_RATE))
        begin
            next_s.rate    = i_wdata; // RL7
            next_s.acc     = 24'h000000;
            next_s.os_tick = 1'b0;
        end

        // Transmitter.
        if (s.os_tick && (s.tx_state != HUBC_IDLE))
        begin
            next_s.tx_os = s.tx_os + 4'h1;
        end
        unique case (s.tx_state)
            HUBC_IDLE:
            begin
                if (fifo_valid)
                begin
                    next_s.tx_shift = fifo_data;
                    next_s.tx_os    = 4'h0;
                    next_s.tx_state = HUBC_START; // RL3
                end
            end
            HUBC_START:
            begin
                if (tx_bit_end)
                begin
                    next_s.tx_bit   = 3'h0;
                    next_s.tx_state = HUBC_DATA;
                end
            end
            HUBC_DATA:
            begin
                if (tx_bit_end)
                begin
                    next_s.tx_shift = {1'b0, s.tx_shift[7:1]}; // RL9
                    next_s.tx_bit   = s.tx_bit + 3'h1;
                    if (s.tx_bit == DATA_LAST)
                    begin
                        next_s.tx_state = HUBC_STOP; // RL4
                    end
                end
            end
            HUBC_STOP:
            begin
                if (tx_bit_end)
                begin
                    next_s.tx_state = HUBC_IDLE;
                end
            end
        endcase
        unique case (next_s.tx_state)
            HUBC_START: next_s.txd = 1'b0;
            HUBC_DATA:  next_s.txd = next_s.tx_shift[0];
            HUBC_STOP:  next_s.txd = 1'b1;
            HUBC_IDLE:  next_s.txd = 1'b1; // RL9
        endcase

        // Receiver; the start edge is confirmed at mid-bit, and each later
        // sample then falls one full bit on, near the middle of its bit.
        if (s.os_tick && (s.rx_state != HUBC_IDLE))
        begin
            next_s.rx_os = s.rx_os + 4'h1;
        end
        unique case (s.rx_state)
            HUBC_IDLE:
            begin
                if (s.os_tick && !i_rxd)
                begin
                    next_s.rx_os    = 4'h0;
                    next_s.rx_state = HUBC_START;
                end
            end
            HUBC_START:
            begin
                if (s.os_tick && (s.rx_os == OS_MID))
                begin
                    next_s.rx_os    = 4'h0;
                    next_s.rx_bit   = 3'h0;
                    next_s.rx_state = i_rxd ? HUBC_IDLE : HUBC_DATA;
                end
            end
            HUBC_DATA:
            begin
                if (s.os_tick && (s.rx_os == OS_LAST))
                begin
                    next_s.rx_shift = {i_rxd, s.rx_shift[7:1]}; // RL9
                    next_s.rx_bit   = s.rx_bit + 3'h1;
                    if (s.rx_bit == DATA_LAST)
                    begin
                        next_s.rx_state = HUBC_STOP; // RL3
                    end
                end
            end
            HUBC_STOP:
            begin
                if (rx_byte_done)
                begin
                    next_s.rx_state = HUBC_IDLE; // RL4
                end
            end
        endcase

        // Flags: a read clears them, but a new event in that cycle wins.
        if (rd_data)
        begin
            next_s.rx_valid = 1'b0;
        end
        if (rd_status)
        begin
            next_s.rx_overrun   = 1'b0;
            next_s.rx_frame_err = 1'b0;
        end
        if (rx_byte_done)
        begin
            next_s.rx_data  = s.rx_shift;
            next_s.rx_valid = 1'b1;
            if (s.rx_valid && !rd_data)
            begin
                next_s.rx_overrun = 1'b1;
            end
            if (!i_rxd)
            begin
                next_s.rx_frame_err = 1'b1;
            end
        end

        // Read data stand for exactly one cycle.
        next_s.rdata = 8'h00;
        if (i_rd)
        begin
            unique case (i_addr)
                ADDR_DATA:   next_s.rdata = s.rx_data;
                ADDR_STATUS:
                begin
                    next_s.rdata[ST_RX_VALID]     = s.rx_valid;
                    next_s.rdata[ST_RX_OVERRUN]   = s.rx_overrun;
                    next_s.rdata[ST_RX_FRAME_ERR] = s.rx_frame_err;
                    next_s.rdata[ST_TX_FULL]      = !fifo_ready;
                    next_s.rdata[ST_TX_BUSY]      = (s.tx_state != HUBC_IDLE) || fifo_valid;
                end
                ADDR_RATE:   next_s.rdata = s.rate;
                default:     next_s.rdata = 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s          <= '0;
            s.rate     <= RATE_RST; // RL6
            s.txd      <= 1'b1;
            s.tx_state <= HUBC_IDLE;
            s.rx_state <= HUBC_IDLE;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign o_txd   = s.txd;
    assign o_rdata = s.rdata;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!rst_n);

    logic rst_n_d;
    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rst_n_d <= 1'b0;
        end
        else
        begin
            rst_n_d <= rst_n;
        end
    end

    AST_RESET_RATE: assert property (!rst_n_d |-> s.rate == 8'h7a) // RL6
        else $error("rate register not at reset value after release");
    AST_DIV_EXP_ZERO: assert property (s.rate[7:5] == 3'h0 |-> div_ticks == 13'(s.rate[4:0]) + 13'h0001) // RL1
        else $error("divisor wrong for zero exponent");
    AST_DIV_EXP_NONZERO: assert property (s.rate[7:5] != 3'h0 // RL2
        |-> div_ticks == ((13'(s.rate[4:0]) + 13'h0021) << (s.rate[7:5] - 3'h1)))
        else $error("divisor wrong for nonzero exponent");
    AST_RATE_WRITE: assert property (i_wr && i_addr == ADDR_RATE |=> s.rate == $past(i_wdata)) // RL7
        else $error("rate write not taken");
    AST_START_LOW: assert property ($fell(o_txd) && $past(s.tx_state) == HUBC_IDLE // RL3
        |-> s.tx_state == HUBC_START ##1 !o_txd)
        else $error("frame did not open with a low start bit");
    AST_NO_PARITY: assert property (s.tx_state == HUBC_DATA && s.tx_bit == 3'h7 && tx_bit_end // RL4
        |=> s.tx_state == HUBC_STOP && o_txd)
        else $error("stop bit did not follow eighth data bit");
    AST_IDLE_HIGH: assert property (s.tx_state == HUBC_IDLE && $past(s.tx_state) == HUBC_IDLE |-> o_txd) // RL9
        else $error("line not high while idle");
    AST_RX_DELIVER: assert property (rx_byte_done |=> s.rx_valid && s.rx_data == $past(s.rx_shift)) // RL3
        else $error("received byte not delivered");
    AST_READ_ONE_CYCLE: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside answer cycle");

    COV_TX_FRAME: cover property (s.tx_state == HUBC_STOP ##1 s.tx_state == HUBC_IDLE);
    COV_RX_BYTE: cover property (rx_byte_done);
    COV_RATE_FAST: cover property (i_wr && i_addr == ADDR_RATE && i_wdata == 8'h15);
    COV_RX_OVERRUN: cover property ($rose(s.rx_overrun));

endmodule // hubc_uart

/* hubc_pkg.sv */
package hubc_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_DATA        = 8'h00;
    localparam logic [7:0] ADDR_STATUS      = 8'h01;
    localparam logic [7:0] ADDR_RATE        = 8'h3b;
    localparam logic [7:0] RATE_RST         = 8'h7a;
    localparam int         EXP_MSB          = 7;
    localparam int         EXP_LSB          = 5;
    localparam int         MAN_MSB          = 4;
    localparam int         MAN_LSB          = 0;

    // Status register bit positions.
    localparam int         ST_RX_VALID      = 0;
    localparam int         ST_RX_OVERRUN    = 1;
    localparam int         ST_RX_FRAME_ERR  = 2;
    localparam int         ST_TX_FULL       = 3;
    localparam int         ST_TX_BUSY       = 4;

    // ----------------------------------------------------------------
    // Rate generation
    // ----------------------------------------------------------------
    // Frequencies in units of 10 kHz so the ratio stays exact in integers.
    localparam int         REF_FREQ_10KHZ   = 2712;
    localparam int         MCLK_FREQ_10KHZ  = 2500;
    localparam int         OVERSAMPLE       = 16;
    localparam logic [23:0] ACC_STEP        = 24'(REF_FREQ_10KHZ * OVERSAMPLE);
    localparam logic [11:0] MCLK_WEIGHT     = 12'(MCLK_FREQ_10KHZ);
    localparam logic [5:0] MAN_OFFSET_EXP   = 6'h21;
    localparam logic [3:0] OS_LAST          = 4'(OVERSAMPLE - 1);
    localparam logic [3:0] OS_MID           = 4'(OVERSAMPLE / 2 - 1);
    localparam logic [2:0] DATA_LAST        = 3'h7;
    localparam int         TX_FIFO_DEPTH    = 4;

    typedef enum logic [1:0] {HUBC_IDLE, HUBC_START, HUBC_DATA, HUBC_STOP} hubc_ser_t;

endpackage

/* hubc_fifo.sv */
`timescale 1ns/1ps

module hubc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             i_mclk,      // Clock
    input  wire logic             i_rst_n,     // Synchronised reset, active low
    input  wire logic             i_in_valid,  // Write request
    output logic                  o_in_ready,  // Space available
    input  wire logic [WIDTH-1:0] i_in_data,   // Write data
    output logic                  o_out_valid, // Data available
    input  wire logic             i_out_ready, // Consumer takes the head
    output logic [WIDTH-1:0]      o_out_data   // Head word
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wr_ptr;
        logic [PW-1:0]               rd_ptr;
        logic [CW-1:0]               count;
    } hubc_fifo_t;

    hubc_fifo_t s;
    hubc_fifo_t next_s;
    logic       push;
    logic       pop;

    assign o_in_ready  = (s.count != CW'(DEPTH));
    assign o_out_valid = (s.count != '0);
    assign o_out_data  = s.mem[s.rd_ptr];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = i_out_ready && o_out_valid;

    always_comb
    begin
        next_s = s;
        if (push)
        begin
            next_s.mem[s.wr_ptr] = i_in_data;
            next_s.wr_ptr = (s.wr_ptr == PW'(DEPTH - 1)) ? '0 : s.wr_ptr + 1'b1;
        end
        if (pop)
        begin
            next_s.rd_ptr = (s.rd_ptr == PW'(DEPTH - 1)) ? '0 : s.rd_ptr + 1'b1;
        end
        if (push && !pop)
        begin
            next_s.count = s.count + 1'b1;
        end
        else if (pop && !push)
        begin
            next_s.count = s.count - 1'b1;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    AST_FIFO_NO_OVERFILL: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        s.count <= CW'(DEPTH)) else $error("fifo count above depth");

endmodule // hubc_fifo

/* hubc_host_model.sv */
`timescale 1ns/1ps

module hubc_host_model
    import hubc_pkg::*;
(
    input  wire logic       i_mclk, // Bench clock, paces the host transmitter
    input  wire logic [7:0] i_rate, // Rate code the host has programmed
    input  wire logic       i_line, // Serial line from the device
    output logic            o_line, // Serial line to the device
    output logic            o_got,  // One-cycle pulse per received character
    output logic      [8:0] o_char  // Stop level and data of that character
);
    // ----------------------------------------------------------------
    // Bit period expected from the rate code
    // ----------------------------------------------------------------
    function automatic real bit_ns(input logic [7:0] code);
        int div;
        if (code[EXP_MSB:EXP_LSB] == 3'h0)
            div = int'(code[MAN_MSB:MAN_LSB]) + 1;
        else
            div = (int'(code[MAN_MSB:MAN_LSB]) + 33) << (code[EXP_MSB:EXP_LSB] - 1);
        return div * 1000.0 / 27.12;
    endfunction

    // Transmit is paced in whole clock cycles, so the rounding error stays
    // below half a cycle per bit and far inside the receiver's margin.
    task automatic send(input logic [7:0] b);
        logic [9:0] frame;
        int         n;
        frame = {1'b1, b, 1'b0};
        n = int'(bit_ns(i_rate) / 40.0);
        for (int i = 0; i < 10; i++)
        begin
            o_line <= frame[i];
            repeat (n) @(posedge i_mclk);
        end
    endtask

    // ----------------------------------------------------------------
    // Receiver, sampling in the middle of each bit
    // ----------------------------------------------------------------
    initial
    begin
        real        per;
        logic [7:0] b;
        o_line <= 1'b1;
        o_got  <= 1'b0;
        o_char <= 9'h000;
        forever
        begin
            @(negedge i_line);
            per = bit_ns(i_rate);
            #(per / 2.0);
            if (i_line === 1'b0)
            begin
                for (int i = 0; i < 8; i++)
                begin
                    #(per);
                    b[i] = i_line;
                end
                #(per);
                @(posedge i_mclk);
                o_char <= {i_line, b};
                o_got  <= 1'b1;
                @(posedge i_mclk);
                o_got  <= 1'b0;
            end
        end
    end
endmodule // hubc_host_model

/* hubc_uart_tb.sv */
`timescale 1ns/1ps

module hubc_uart_tb
    import hubc_pkg::*;
;
    logic        i_mclk = 1'b0;
    logic        i_rst_b;
    logic [7:0]  i_addr;
    logic [7:0]  i_wdata;
    logic        i_wr;
    logic        i_rd;
    logic [7:0]  o_rdata;
    logic        rxd;
    logic        txd;
    logic [7:0]  rate;
    logic        got;
    logic [8:0]  char;
    logic [7:0]  rd_q[$];
    logic [8:0]  ser_q[$];
    logic        rd_pend = 1'b0;
    int          bad_count = 0;
    int          n_compared = 0;
    int          seed = 32'h109e0d56;
    logic [7:0]  codes[6];
    logic [7:0]  b;
    logic [31:0] r;

    always #20 i_mclk = ~i_mclk;

    hubc_uart i_dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_rxd(rxd), .o_txd(txd));
    hubc_host_model i_host (.i_mclk(i_mclk), .i_rate(rate), .i_line(txd), .o_line(rxd), .o_got(got),
        .o_char(char));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] seen);
        n_compared++;
        if (exp !== seen)
        begin
            $display("FAIL %s expected %h seen %h", what, exp, seen);
            bad_count++;
        end
    endtask

    // One bus cycle; an all-zero call is an idle cycle that drops the strobes.
    task automatic op(input logic w, input logic rs, input logic [7:0] a, input logic [7:0] d);
        i_wr    <= w;
        i_rd    <= rs;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_mclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        rd_q.push_back(exp);
        op(1'b0, 1'b1, a, 8'h00);
    endtask

    task automatic drain();
        for (int i = 0; i < 20000 && ser_q.size() > 0; i++)
            @(posedge i_mclk);
        repeat (300) @(posedge i_mclk);
    endtask

    task automatic end_of_test();
        if (bad_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Result watcher
    // ----------------------------------------------------------------
    always @(posedge i_mclk)
    begin
        if (rd_pend)
            chk("rdata", {1'b0, (rd_q.size() > 0) ? rd_q.pop_front() : 8'hxx}, {1'b0, o_rdata});
        else if (i_rst_b)
            chk("rdata idle", 9'h000, {1'b0, o_rdata});
        rd_pend = i_rd;
        if (got)
            chk("serial char", (ser_q.size() > 0) ? ser_q.pop_front() : 9'hxxx, char);
    end

    initial
    begin
        repeat (90000) @(posedge i_mclk);
        bad_count++;
        end_of_test();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        i_rst_b = 1'b0;
        i_addr  = 8'h00;
        i_wdata = 8'h00;
        i_wr    = 1'b0;
        i_rd    = 1'b0;
        rate    = RATE_RST;
        repeat (3) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        repeat (3) @(posedge i_mclk);
        rd(ADDR_RATE, RATE_RST);
        op(1'b1, 1'b0, 8'h3c, 8'hff);
        rd(8'h3c, 8'h00);
        rd(ADDR_STATUS, 8'h00);
        codes = '{RATE_RST, 8'h3a, 8'h1c, 8'h15, 8'h00, 8'h00};
        for (int k = 4; k < 6; k++)
        begin
            r = $random(seed);
            // Random codes keep the divisor at 25 or more, below the fastest supported rate.
            codes[k] = {(r[8:7] == 2'h3) ? 3'h1 : {1'b0, r[8:7]}, 2'h3, r[4:2]};
        end
        foreach (codes[k])
        begin
            op(1'b1, 1'b0, ADDR_RATE, codes[k]);
            rd(ADDR_RATE, codes[k]);
            rate <= codes[k];
            for (int i = 0; i < 2; i++)
            begin
                b = 8'($random(seed));
                ser_q.push_back({1'b1, b});
                op(1'b1, 1'b0, ADDR_DATA, b);
            end
            op(1'b0, 1'b0, 8'h00, 8'h00);
            drain();
            b = 8'($random(seed));
            i_host.send(b);
            repeat (20) @(posedge i_mclk);
            rd(ADDR_STATUS, 8'h01);
            rd(ADDR_DATA, b);
            rd(ADDR_STATUS, 8'h00);
            op(1'b0, 1'b0, 8'h00, 8'h00);
        end
        op(1'b1, 1'b0, ADDR_RATE, 8'h15);
        rate <= 8'h15;
        for (int i = 0; i < 6; i++)
        begin
            b = 8'($random(seed));
            if (i < 5)
                ser_q.push_back({1'b1, b});
            op(1'b1, 1'b0, ADDR_DATA, b);
        end
        rd(ADDR_STATUS, 8'h18);
        op(1'b0, 1'b0, 8'h00, 8'h00);
        drain();
        rd(ADDR_STATUS, 8'h00);
        op(1'b0, 1'b0, 8'h00, 8'h00);
        b = 8'($random(seed));
        i_host.send(8'h5a);
        i_host.send(b);
        repeat (20) @(posedge i_mclk);
        rd(ADDR_STATUS, 8'h03);
        rd(ADDR_DATA, b);
        rd(ADDR_STATUS, 8'h00);
        op(1'b0, 1'b0, 8'h00, 8'h00);
        i_rst_b <= 1'b0;
        repeat (3) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        repeat (3) @(posedge i_mclk);
        rd(ADDR_RATE, RATE_RST);
        op(1'b0, 1'b0, 8'h00, 8'h00);
        repeat (3) @(posedge i_mclk);
        chk("pending chars", 9'h000, 9'(ser_q.size()));
        end_of_test();
    end
endmodule // hubc_uart_tb
